// ==== bench/accessory_expect.svh ====
// Expected source level and delay class of each output function
function automatic logic want(input logic [5:0] c,
	input logic [15:0] s, input logic [15:0] w, input int i);
	case (c)
	FN_ALWAYS_ON: return 1'b1;
	FN_ERROR: return s[3];
	FN_NO_ERROR: return !s[3];
	FN_WARNING: return s[14];
	FN_NO_WARNING: return !s[14];
	FN_NORMAL: return s[10];
	FN_NOT_NORMAL: return !s[10];
	FN_TURNING, FN_FAN_TURNING: return s[11];
	FN_STANDSTILL: return !s[11];
	FN_START_PRESENT, FN_READY: return s[0];
	FN_ACCEL: return s[4];
	FN_DECEL: return s[5];
	FN_FIELDBUS, FN_PURGE_OPEN: return w[i == 0 ? 5 : i == 1 ? 14 : 15];
	FN_PURGE_START, FN_RELAY_START: return w[0];
	default: return 1'b0;
	endcase
endfunction
// Codes routed through the per-output delay pair
function automatic logic slow(input logic [5:0] c);
	return c inside {6'h08, 6'h12, 6'h1b, 6'h1f, 6'h21, 6'h22};
endfunction

// ==== bench/accessory_load_model.sv ====
// Behavioural relay, fan and valve loads on the three outputs
module accessory_load_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] drive,
	output logic [2:0][7:0] on_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] last;
	// A load only acts on a rising drive, so count switch-ons
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			last <= 3'h0;
			on_count <= '0;
		end else begin
			last <= drive;
			for (int i = 0; i < 3; i++) begin
				if (drive[i] && !last[i]) begin
					on_count[i] <= on_count[i] + 8'h01;
				end
			end
		end
	end
endmodule

// ==== bench/accessory_output_function_select_bench.sv ====
// Self-checking bench for the accessory output selector
module accessory_output_function_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import accessory_pkg::*;
	localparam int MS = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	logic [15:0] sw = 16'h0000;
	logic [15:0] cw = 16'h0000;
	wire logic [2:0] outs;
	logic [2:0][7:0] loads;
	logic [31:0] rd;
	logic err;
	logic lvl;
	logic [7:0] base;
	int n_mismatch = 0;
	int checked = 0;
	int seed = 32'hfe0f93cb;
	int fast [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 19, 26, 28, 37, 38, 23, 63};
	int slowc [6] = '{8, 18, 27, 31, 33, 34};
	`include "accessory_expect.svh"
	always #4 clk = ~clk;
	accessory_output_select #(.CYCLES_PER_MS(17'(MS))) DUT (
		.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
		.status_word(sw), .control_word(cw), .accessory_output_a(outs[0]),
		.accessory_output_b(outs[1]), .accessory_output_c(outs[2]));
	accessory_load_model loads_model (.clk(clk), .rst(rst), .drive(outs),
		.on_count(loads));
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d, 4'hf};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 50) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic words(input logic [15:0] v);
		@(posedge clk);
		sw <= v;
		cw <= v;
	endtask
	// Bounded wait for an output level, with a minimum switch time
	task automatic wait_out(input int i, input logic l, input int lo,
		input int hi);
		int n;
		n = 0;
		while (outs[i] !== l && n < hi) begin
			@(negedge clk);
			n++;
		end
		check("switch time", n >= lo && n < hi, 1'b1);
		if (n >= hi) report_and_stop();
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 8'(4 * (i % 3) + 16 * (i / 3)), 32'h0);
			check("reset", rd, i == 0 ? 32'h1c : i == 1 ? 32'h22 : 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'(16 + 4 * i), 32'h2);
			apb(1'b1, 8'(32 + 4 * i), 32'h1);
		end
		// Undelayed codes with random words; stored delays must not act
		foreach (fast[k]) for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'(4 * i), 32'(fast[k]));
			repeat (4) begin
				@(posedge clk);
				sw <= 16'($random(seed));
				cw <= 16'($random(seed));
				repeat (3) @(negedge clk);
				check("fast out", outs[i], want(6'(fast[k]), sw, cw, i));
			end
		end
		// Delayed codes: short glitch ignored, then timed on and off
		foreach (slowc[k]) for (int i = 0; i < 3; i++) begin
			words(16'h0000);
			apb(1'b1, 8'(4 * i), 32'(slowc[k]));
			lvl = want(6'(slowc[k]), 16'h0000, 16'h0000, i);
			wait_out(i, lvl, 0, 40);
			words(16'hffff);
			repeat (5) @(posedge clk);
			base = loads[i];
			words(16'h0000);
			repeat (30) @(negedge clk);
			check("glitch", outs[i], lvl);
			words(16'hffff);
			wait_out(i, !lvl, lvl ? MS - 1 : 2 * MS - 1, 3 * MS + 6);
			words(16'h0000);
			wait_out(i, lvl, lvl ? 2 * MS - 1 : MS - 1, 3 * MS + 6);
			repeat (2) @(negedge clk);
			check("load switch-ons", loads[i], 8'(base + 8'h01));
		end
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, 8'(16 * (1 + i / 3) + 4 * (i % 3)), 32'h0);
			check("delay kept", rd, i < 3 ? 32'h2 : 32'h1);
		end
		apb(1'b1, REG_STATUS, 32'h1);
		check("ro write err", err, 1'b1);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h04, 32'(FN_ALWAYS_ON));
		words(16'h1234);
		apb(1'b0, REG_OUTPUTS, 32'h0);
		check("outputs reg", rd, 32'h2);
		apb(1'b0, REG_CONTROL, 32'h0);
		check("control reg", rd, 32'h1234);
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end
endmodule

// ==== bench/accessory_output_select_asserts.sv ====
// Port checks for the accessory output selector
module accessory_output_select_asserts
	import accessory_pkg::*;
#(
	parameter logic [accessory_pkg::DIV_W-1:0] CYCLES_PER_MS = 17'h0000a
)
(
	input wire logic clk,
	input wire logic rst,
	input wire accessory_pkg::apb_req_t apb_req,
	input wire accessory_pkg::apb_rsp_t apb_rsp,
	input wire logic [accessory_pkg::WORD_W-1:0] status_word,
	input wire logic [accessory_pkg::WORD_W-1:0] control_word,
	input wire logic accessory_output_a,
	input wire logic accessory_output_b,
	input wire logic accessory_output_c
);
	timeunit 1ns;
	timeprecision 1ps;
	`include "accessory_expect.svh"
	logic [2:0] outs;
	logic [2:0] src_q;
	logic [2:0][5:0] code;
	logic [2:0][1:0] age;
	logic wr;
	assign outs = {accessory_output_c, accessory_output_b, accessory_output_a};
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Shadow codes; age keeps checks off while a new code settles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code <= {FUNC_RESET_C, FUNC_RESET_B, FUNC_RESET_A};
			age <= '0;
			src_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				src_q[i] <= want(code[i], status_word, control_word, i);
				if (wr && apb_req.pstrb[0] && apb_req.paddr == 8'(4 * i)) begin
					code[i] <= apb_req.pwdata[5:0];
					age[i] <= 2'h0;
				end else if (age[i] != 2'h3) begin
					age[i] <= age[i] + 2'h1;
				end
			end
		end
	end
	sequence access_s;
		apb_req.psel && apb_req.penable;
	endsequence
	sequence quiet_s;
		$stable(status_word) && $stable(control_word) &&
		status_word == $past(status_word, 2) &&
		control_word == $past(control_word, 2);
	endsequence
	ready_high_a: assert property (apb_rsp.pready)
		else $error("pready low");
	err_in_access_a: assert property (apb_rsp.pslverr |-> access_s)
		else $error("pslverr outside access");
	ro_write_err_a: assert property (access_s ##0
		(apb_req.pwrite && apb_req.paddr == REG_STATUS) |-> apb_rsp.pslverr)
		else $error("read-only write accepted");
	unmapped_err_a: assert property (access_s ##0
		apb_req.paddr >= 8'h3c |-> apb_rsp.pslverr)
		else $error("unmapped access accepted");
	for (genvar i = 0; i < 3; i++) begin : per_out
		const_level_a: assert property (
			age[i] == 2'h3 && (code[i] == FN_ALWAYS_OFF ||
			code[i] == FN_ALWAYS_ON) |-> outs[i] == (code[i] == FN_ALWAYS_ON))
			else $error("constant output wrong");
		follow_src_a: assert property (
			quiet_s ##0 (age[i] == 2'h3 && !slow(code[i])) |->
			outs[i] == want(code[i], status_word, control_word, i))
			else $error("output not following source");
		delay_rise_a: assert property (
			age[i] == 2'h3 && slow(code[i]) && $rose(outs[i]) |->
			src_q[i] || $past(src_q[i]))
			else $error("delayed output rose without source");
		delay_fall_a: assert property (
			age[i] == 2'h3 && slow(code[i]) && $fell(outs[i]) |->
			!src_q[i] || !$past(src_q[i]))
			else $error("delayed output fell with source on");
	end
endmodule
bind accessory_output_select accessory_output_select_asserts #(
	.CYCLES_PER_MS(CYCLES_PER_MS)
) checker_inst (
	.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.status_word(status_word), .control_word(control_word),
	.accessory_output_a(accessory_output_a),
	.accessory_output_b(accessory_output_b),
	.accessory_output_c(accessory_output_c)
);

// ==== rtl/accessory_output_select.sv ====
// Function select and delay control for three accessory outputs, APB slave
//
// Contract
// - Code 0 holds the output off whatever the status and control bits.
// - Code 1 follows status bit 3, the active error flag.
// - Code 2 is on while the active error bit is clear.
// - Code 3 follows status bit 14, the collective warning.
// - Code 4 is on while no collective warning is present.
// - Code 5 follows status bit 10, normal operation reached.
// - Code 6 is on while normal operation is not reached.
// - Codes 7 and 28 follow status bit 11, rotor turning.
// - Code 19 holds the output on permanently.
// - Code 26 follows status bit 0, start command present.
// - Code 37 follows status bit 4, rotor accelerating.
// - Code 38 follows status bit 5, rotor decelerating.
// - Each output has programmable switch-on and switch-off delays in ms.
// - One delay pair per output, shared by every delayed function.
// - Changing a function code leaves the stored delays untouched.
// - Functions without delays ignore the stored delays entirely.
// - Code 18 follows the output's own control bit, with delays.
// - Code 31 uses control bits 5, 14, 15 per output, with delays.
// - Code 27 follows status bit 0, ready, with delays.
// - Codes 33 and 34 follow control bit 0, start, with delays.
// - Code 8 is on while status bit 11 is clear, with delays.
//
// The register addresses and the APB slave port are this design's own decisions.
module accessory_output_select
	import accessory_pkg::*;
#(
	parameter logic [accessory_pkg::DIV_W-1:0] CYCLES_PER_MS =
		accessory_pkg::DIV_W'(accessory_pkg::MS_TIME_NS /
		accessory_pkg::CLK_PERIOD_NS)
)
(
	input wire logic clk,
	input wire logic rst,
	input wire accessory_pkg::apb_req_t apb_req,
	output accessory_pkg::apb_rsp_t apb_rsp,
	input wire logic [accessory_pkg::WORD_W-1:0] status_word,
	input wire logic [accessory_pkg::WORD_W-1:0] control_word,
	output logic accessory_output_a,
	output logic accessory_output_b,
	output logic accessory_output_c
);

	import accessory_pkg::*;

	typedef struct packed {
		logic [NUM_OUTPUTS-1:0][FUNC_W-1:0] func_code;
		logic [NUM_OUTPUTS-1:0][DELAY_W-1:0] on_delay;
		logic [NUM_OUTPUTS-1:0][DELAY_W-1:0] off_delay;
		logic [DIV_W-1:0] div_count;
		logic [DATA_W-1:0] prdata;
		logic pslverr;
	} select_state_t;

	select_state_t state;
	select_state_t next_state;
	logic ms_tick;
	logic setup_phase;
	logic write_commit;
	logic [NUM_OUTPUTS-1:0] out_level;
	source_sel_t [NUM_OUTPUTS-1:0] source;
	logic [NUM_OUTPUTS-1:0][3:0] own_cw_bit;

	// Control word bit owned by each output
	// Used by codes 18 and 31 alike
	assign own_cw_bit[0] = 4'(CW_OUT_A);
	assign own_cw_bit[1] = 4'(CW_OUT_B);
	assign own_cw_bit[2] = 4'(CW_OUT_C);

	// Map a function code onto its source bit and delay use
	// Undelayed codes still pass the timer flop, one edge late
	// Delayed codes set use_delay and share the output's delay pair
	// Limit-value codes are not decoded and fall to the default
	// A code that is not listed leaves the output off
	function automatic source_sel_t select_source(
		input logic [FUNC_W-1:0] code,
		input logic [WORD_W-1:0] sw,
		input logic [WORD_W-1:0] cw,
		input logic [3:0] cw_bit
	);
		source_sel_t sel;
		sel.use_delay = 1'b0;
		sel.level = 1'b0;
		unique case (code)
			FN_ALWAYS_OFF: begin
				sel.level = 1'b0;
			end
			FN_ERROR: begin
				sel.level = sw[SW_ERROR];
			end
			FN_NO_ERROR: begin
				sel.level = !sw[SW_ERROR];
			end
			FN_WARNING: begin
				sel.level = sw[SW_WARNING];
			end
			FN_NO_WARNING: begin
				sel.level = !sw[SW_WARNING];
			end
			FN_NORMAL: begin
				sel.level = sw[SW_NORMAL];
			end
			FN_NOT_NORMAL: begin
				sel.level = !sw[SW_NORMAL];
			end
			FN_TURNING, FN_FAN_TURNING: begin
				sel.level = sw[SW_TURNING];
			end
			FN_ALWAYS_ON: begin
				sel.level = 1'b1;
			end
			FN_START_PRESENT: begin
				sel.level = sw[SW_START];
			end
			FN_ACCEL: begin
				sel.level = sw[SW_ACCEL];
			end
			FN_DECEL: begin
				sel.level = sw[SW_DECEL];
			end
			FN_STANDSTILL: begin
				sel.use_delay = 1'b1;
				sel.level = !sw[SW_TURNING];
			end
			FN_FIELDBUS: begin
				sel.use_delay = 1'b1;
				sel.level = cw[cw_bit];
			end
			FN_PURGE_OPEN: begin
				sel.use_delay = 1'b1;
				sel.level = cw[cw_bit];
			end
			FN_READY: begin
				sel.use_delay = 1'b1;
				sel.level = sw[SW_START];
			end
			FN_PURGE_START, FN_RELAY_START: begin
				sel.use_delay = 1'b1;
				sel.level = cw[CW_START];
			end
			default: begin
				sel.use_delay = 1'b0;
				sel.level = 1'b0;
			end
		endcase
		return sel;
	endfunction

	// Merge write data into a register under byte strobes
	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0] old_value,
		input logic [DATA_W-1:0] wdata,
		input logic [STRB_W-1:0] strb
	);
		logic [DATA_W-1:0] result;
		result = old_value;
		for (int b = 0; b < STRB_W; b++) begin
			if (strb[b]) begin
				result[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return result;
	endfunction

	// Register map, one aligned word each:
	// 0x00, 0x04, 0x08 function code of outputs a, b, c, bits 5:0
	// 0x10, 0x14, 0x18 switch-on delay of outputs a, b, c, in ms
	// 0x20, 0x24, 0x28 switch-off delay of outputs a, b, c, in ms
	// 0x30 status word, read only
	// 0x34 control word, read only
	// 0x38 output levels, bit 0 is output a, read only
	// Writes to read-only or unmapped words answer with an error
	// and change nothing; unmapped reads return zero
	// Upper bits of every word read as zero

	// Index of a per-output register, or NUM_OUTPUTS when not in the group
	function automatic logic [1:0] group_index(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] base
	);
		logic [1:0] idx;
		idx = 2'(NUM_OUTPUTS);
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			if (addr == base + ADDR_W'(i) * REG_STRIDE) begin
				idx = 2'(i);
			end
		end
		return idx;
	endfunction

	// Bus phases; every access completes without wait states
	// Read data and error are latched at the setup edge, so a read
	// returns the word as it stood one edge before the access phase
	// Writes land at the access edge, the one where pready is seen
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign write_commit = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign ms_tick = (state.div_count == CYCLES_PER_MS - 1'b1);

	// Source selection, one per output
	// Status and control words are used as sampled, no filtering
	always_comb begin
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			source[i] = select_source(state.func_code[i], status_word,
				control_word, own_cw_bit[i]);
		end
	end

	// Register file, bus answer and millisecond divider
	// Only the register groups take writes; the rest are read only
	always_comb begin
		logic [1:0] fidx;
		logic [1:0] nidx;
		logic [1:0] oidx;
		logic [DATA_W-1:0] merged;
		fidx = group_index(apb_req.paddr, REG_FUNC_BASE);
		nidx = group_index(apb_req.paddr, REG_ON_BASE);
		oidx = group_index(apb_req.paddr, REG_OFF_BASE);
		merged = '0;
		next_state = state;

		// Free-running ms divider shared by all outputs
		// The tick is one cycle wide and reaches all timers together
		if (ms_tick) begin
			next_state.div_count = '0;
		end else begin
			next_state.div_count = state.div_count + 1'b1;
		end

		// Read data and error are prepared in the setup cycle
		if (setup_phase) begin
			next_state.prdata = '0;
			next_state.pslverr = 1'b0;
			if (fidx != 2'(NUM_OUTPUTS)) begin
				next_state.prdata = DATA_W'(state.func_code[fidx]);
			end else if (nidx != 2'(NUM_OUTPUTS)) begin
				next_state.prdata = DATA_W'(state.on_delay[nidx]);
			end else if (oidx != 2'(NUM_OUTPUTS)) begin
				next_state.prdata = DATA_W'(state.off_delay[oidx]);
			end else if (apb_req.paddr == REG_STATUS) begin
				next_state.prdata = DATA_W'(status_word);
				next_state.pslverr = apb_req.pwrite;
			end else if (apb_req.paddr == REG_CONTROL) begin
				next_state.prdata = DATA_W'(control_word);
				next_state.pslverr = apb_req.pwrite;
			end else if (apb_req.paddr == REG_OUTPUTS) begin
				next_state.prdata = DATA_W'(out_level);
				next_state.pslverr = apb_req.pwrite;
			end else begin
				// Unmapped address answers with an error
				next_state.pslverr = 1'b1;
			end
		end

		// Writes land in the access cycle
		if (write_commit) begin
			if (fidx != 2'(NUM_OUTPUTS)) begin
				merged = merge_bytes(DATA_W'(state.func_code[fidx]),
					apb_req.pwdata, apb_req.pstrb);
				next_state.func_code[fidx] = merged[FUNC_W-1:0];
			end else if (nidx != 2'(NUM_OUTPUTS)) begin
				merged = merge_bytes(DATA_W'(state.on_delay[nidx]),
					apb_req.pwdata, apb_req.pstrb);
				next_state.on_delay[nidx] = merged[DELAY_W-1:0];
			end else if (oidx != 2'(NUM_OUTPUTS)) begin
				merged = merge_bytes(DATA_W'(state.off_delay[oidx]),
					apb_req.pwdata, apb_req.pstrb);
				next_state.off_delay[oidx] = merged[DELAY_W-1:0];
			end
		end
	end

	// Single state register
	// Outputs a and b wake with their working codes, c stays off;
	// delays start at zero so a delayed code first switches at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state.func_code[0] <= FUNC_RESET_A;
			state.func_code[1] <= FUNC_RESET_B;
			state.func_code[2] <= FUNC_RESET_C;
			state.on_delay <= {NUM_OUTPUTS{DELAY_RESET}};
			state.off_delay <= {NUM_OUTPUTS{DELAY_RESET}};
			state.div_count <= '0;
			state.prdata <= '0;
			state.pslverr <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// Delay stage per output; bypassed for undelayed functions
	// The ms divider runs free and is shared, so a delayed change
	// waits for the tick after the stored delay has passed
	// The wait is between D and D+1 ms, never shorter, at the cost
	// of up to one ms of extra lag
	// A zero delay switches at the next edge
	// A source that drops back before the wait ends restarts it
	for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
		switch_delay_timer u_timer (
			.clk(clk),
			.rst(rst),
			.ms_tick(ms_tick),
			.source(source[g]),
			.on_delay(state.on_delay[g]),
			.off_delay(state.off_delay[g]),
			.level(out_level[g])
		);
	end

	// Outputs come straight from the timer flops
	// so a load never sees a combinational glitch
	assign accessory_output_a = out_level[0];
	assign accessory_output_b = out_level[1];
	assign accessory_output_c = out_level[2];

	// Zero-wait answer; data and error were registered in setup
	// Error shows only in the access phase, as the bus requires
	assign apb_rsp.prdata = state.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = state.pslverr && apb_req.psel
		&& apb_req.penable;

endmodule

// ==== rtl/accessory_pkg.sv ====
// Shared constants and carrier types for the accessory output selector
package accessory_pkg;

	// Structure sizes
	localparam int unsigned NUM_OUTPUTS = 3;
	localparam int unsigned FUNC_W = 6;
	localparam int unsigned DELAY_W = 16;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned DIV_W = 17;

	// Function codes handled by this block
	localparam logic [5:0] FN_ALWAYS_OFF = 6'h00;
	localparam logic [5:0] FN_ERROR = 6'h01;
	localparam logic [5:0] FN_NO_ERROR = 6'h02;
	localparam logic [5:0] FN_WARNING = 6'h03;
	localparam logic [5:0] FN_NO_WARNING = 6'h04;
	localparam logic [5:0] FN_NORMAL = 6'h05;
	localparam logic [5:0] FN_NOT_NORMAL = 6'h06;
	localparam logic [5:0] FN_TURNING = 6'h07;
	localparam logic [5:0] FN_STANDSTILL = 6'h08;
	localparam logic [5:0] FN_FIELDBUS = 6'h12;
	localparam logic [5:0] FN_ALWAYS_ON = 6'h13;
	localparam logic [5:0] FN_START_PRESENT = 6'h1a;
	localparam logic [5:0] FN_READY = 6'h1b;
	localparam logic [5:0] FN_FAN_TURNING = 6'h1c;
	localparam logic [5:0] FN_PURGE_OPEN = 6'h1f;
	localparam logic [5:0] FN_PURGE_START = 6'h21;
	localparam logic [5:0] FN_RELAY_START = 6'h22;
	localparam logic [5:0] FN_ACCEL = 6'h25;
	localparam logic [5:0] FN_DECEL = 6'h26;

	// Status word bit positions
	localparam int unsigned SW_START = 0;
	localparam int unsigned SW_ERROR = 3;
	localparam int unsigned SW_ACCEL = 4;
	localparam int unsigned SW_DECEL = 5;
	localparam int unsigned SW_NORMAL = 10;
	localparam int unsigned SW_TURNING = 11;
	localparam int unsigned SW_WARNING = 14;

	// Control word bit positions
	localparam int unsigned CW_START = 0;
	localparam int unsigned CW_OUT_A = 5;
	localparam int unsigned CW_OUT_B = 14;
	localparam int unsigned CW_OUT_C = 15;

	// Register byte offsets
	localparam logic [7:0] REG_FUNC_BASE = 8'h00;
	localparam logic [7:0] REG_ON_BASE = 8'h10;
	localparam logic [7:0] REG_OFF_BASE = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h30;
	localparam logic [7:0] REG_CONTROL = 8'h34;
	localparam logic [7:0] REG_OUTPUTS = 8'h38;
	localparam logic [7:0] REG_STRIDE = 8'h04;

	// Reset values
	localparam logic [5:0] FUNC_RESET_A = FN_FAN_TURNING;
	localparam logic [5:0] FUNC_RESET_B = FN_RELAY_START;
	localparam logic [5:0] FUNC_RESET_C = FN_ALWAYS_OFF;
	localparam logic [15:0] DELAY_RESET = 16'h0000;

	// Timing
	localparam int unsigned MS_TIME_NS = 1000000;
	localparam int unsigned CLK_PERIOD_NS = 8;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
		logic [STRB_W-1:0] pstrb;
	} apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic use_delay;
		logic level;
	} source_sel_t;

	typedef struct packed {
		logic level;
		logic [DELAY_W-1:0] count;
	} timer_state_t;

endpackage

// ==== rtl/switch_delay_timer.sv ====
// Per-output switch-on / switch-off delay stage
module switch_delay_timer
	import accessory_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ms_tick,
	input wire accessory_pkg::source_sel_t source,
	input wire logic [accessory_pkg::DELAY_W-1:0] on_delay,
	input wire logic [accessory_pkg::DELAY_W-1:0] off_delay,
	output logic level
);

	timer_state_t state;
	timer_state_t next_state;
	logic [DELAY_W-1:0] target;

	// Pick the delay that applies to the pending change
	always_comb begin
		next_state = state;
		target = state.level ? off_delay : on_delay;
		if (!source.use_delay) begin
			next_state.level = source.level;
			next_state.count = '0;
		end else if (source.level == state.level) begin
			next_state.count = '0;
		end else if (target == '0 ||
			(ms_tick && state.count >= target)) begin
			// switch at once for a zero delay, else on the tick after the delay, never early
			next_state.level = source.level;
			next_state.count = '0;
		end else if (ms_tick) begin
			next_state.count = state.count + 1'b1;
		end
	end

	// Single state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign level = state.level;

endmodule
